// [verilog/mmu_partition_translation.v]
// The APB slave port and the register addresses were left to the implementer.
`timescale 1ns/1ps
`include "mmu_partition_consts.vh"

module mmu_partition_translation #(
   parameter HAS_MMU = 1,
   parameter HAS_MPU = 0,
   parameter HAS_DCACHE = 1,
   parameter [31:0] RESET_VECTOR = 32'hc0000000,
   parameter [31:0] EXC_VECTOR = 32'hc0000020,
   parameter [31:0] BREAK_VECTOR = 32'hc0000040,
   parameter [31:0] FAST_MISS_VECTOR = 32'hc0000060
) (
   input wire ref_clk,
   input wire rst,
   input wire reqValid,
   input wire [31:0] reqVaddr,
   input wire [1:0] reqKind,
   input wire reqIoType,
   input wire reqPrivInstr,
   output reg rspValid,
   output reg [31:0] rspPaddr,
   output reg rspCacheable,
   output reg [2:0] rspCause,
   output reg rspUserMode,
   output reg [31:0] rspVector,
   input wire [31:0] paddr,
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [31:0] pwdata,
   output reg [31:0] prdata,
   output reg pready,
   output reg pslverr
);

// ----------------------------------------------------------------
// configuration and software state
// ----------------------------------------------------------------
localparam USER_OK = (HAS_MMU != 0) || (HAS_MPU != 0);
wire hasDcache = (HAS_DCACHE != 0);
wire vecLow = (RESET_VECTOR[31:29] == 3'h6) && (EXC_VECTOR[31:29] == 3'h6) &&
   (BREAK_VECTOR[31:29] == 3'h6) && (FAST_MISS_VECTOR[31:29] == 3'h6);

reg userMode_q;
reg handlerFlag_q;
reg [`PID_W-1:0] processIdentifier_q;
reg [19:0] stageVpn_q;
reg [`PID_W-1:0] stagePid_q;
reg stageGlobal_q;
reg [19:0] stagePfn_q;
reg [3:0] stagePerm_q;
reg [`TLB_IDX_W-1:0] stageIdx_q;
reg [2:0] lastCause_q;
reg [31:0] lastAddr_q;
reg stageCData_q; // cacheable bit waiting for the commit write

// software-loaded translation table, never written by hardware lookups
reg [19:0] tagVpn [0:`TLB_ENTRIES-1];
reg [`PID_W-1:0] tagPid [0:`TLB_ENTRIES-1];
reg tagGlobal [0:`TLB_ENTRIES-1];
reg [19:0] dataPfn [0:`TLB_ENTRIES-1];
reg [3:0] dataPerm [0:`TLB_ENTRIES-1];
reg dataC [0:`TLB_ENTRIES-1];
// there is no valid bit: an unused entry is parked on a distinct page of the
// peripheral range, which never reaches the lookup because that range bypasses
// the table; software must keep two entries from matching one virtual page,
// otherwise the first matching index gives frame and permission, while the cacheable flags of all matches are ORed

// ----------------------------------------------------------------
// partition decode and lookup
// ----------------------------------------------------------------
// address map seen by the decoder:
//   top eighth      peripheral  bypass, supervisor only, never cached
//   next eighth     kernel      bypass, supervisor only, cached
//   next quarter    kernel xlat table, supervisor only, entry decides
//   lower half      user        table, entry decides user and cache
// bypass clears the top three bits, so it only ever reaches low memory;
// high physical memory is therefore reachable through the table alone
reg [1:0] part;
reg [19:0] hitPfn;
reg [3:0] hitPerm;
reg hit;
reg [31:0] physD;
reg cacheD;
reg [2:0] causeD;
reg permOk;
reg cacheHit;
integer i;
integer m;

// partition from the top three bits, ahead of any lookup
always @* begin
   case (reqVaddr[31:29])
      3'h7: part = `PART_IO;
      3'h6: part = `PART_KERNEL;
      3'h4, 3'h5: part = `PART_KXLAT;
      default: part = `PART_USER;
   endcase
end

// associative match on page number and process identifier
always @* begin
   hit = 1'b0;
   hitPfn = 20'h00000;
   hitPerm = 4'h0;
   for (i = 0; i < `TLB_ENTRIES; i = i + 1) begin
      if (!hit && tagVpn[i] == reqVaddr[`PAGE_MSB:`PAGE_LSB] &&
          (tagGlobal[i] || tagPid[i] == processIdentifier_q)) begin
         hit = 1'b1;
         hitPfn = dataPfn[i];
         hitPerm = dataPerm[i];
      end
   end
end

// translation, permission and cacheability result
// fault priority, highest first:
//   privileged instruction issued at user level
//   user access to a supervisor partition
//   no matching entry (double miss while the handler flag is set)
//   entry present but the needed permission is missing
// a faulting access returns address zero and is never cacheable, so the
// processor can raise a precise exception and retry after a refill
always @* begin
   physD = 32'h00000000;
   cacheD = 1'b0;
   causeD = `EXC_NONE;
   // perm bits: 3 user, 2 read, 1 write, 0 execute
   case (reqKind)
      `ACC_FETCH: permOk = hitPerm[0];
      `ACC_LOAD: permOk = hitPerm[2];
      `ACC_STORE: permOk = hitPerm[1];
      default: permOk = 1'b1;
   endcase
   if (userMode_q && reqPrivInstr) begin
      causeD = `EXC_PRIV_INSTR;
   end else if (userMode_q && part != `PART_USER) begin
      causeD = `EXC_SUPER_ONLY;
   end else if (HAS_MMU == 0) begin
      physD = reqVaddr;
      cacheD = hasDcache && !reqIoType;
   end else if (part == `PART_IO || part == `PART_KERNEL) begin
      physD = {3'h0, reqVaddr[`BYPASS_MSB:0]};
      cacheD = (part == `PART_KERNEL) && hasDcache && !reqIoType;
   end else if (!hit) begin
      causeD = handlerFlag_q ? `EXC_DOUBLE_MISS : `EXC_FAST_MISS;
   end else if (!permOk || (userMode_q && !hitPerm[3])) begin
      causeD = `EXC_PERM;
   end else begin
      physD = {hitPfn, reqVaddr[`OFFSET_MSB:0]};
      cacheD = cacheHit && hasDcache && !reqIoType;
   end
end

// cacheable flags of every matching entry ORed together, address bits 31:12 all compared
// own loop variable, so the two lookup processes share no variable
always @* begin
   cacheHit = 1'b0;
   for (m = 0; m < `TLB_ENTRIES; m = m + 1) begin
      if (tagVpn[m] == reqVaddr[`PAGE_MSB:`PAGE_LSB] &&
          (tagGlobal[m] || tagPid[m] == processIdentifier_q))
         cacheHit = cacheHit | dataC[m];
   end
end

// ----------------------------------------------------------------
// registered answer to the processor
// ----------------------------------------------------------------
always @(posedge ref_clk or posedge rst) begin
   if (rst) begin
      rspValid <= 1'b0;
      rspPaddr <= 32'h00000000;
      rspCacheable <= 1'b0;
      rspCause <= `EXC_NONE;
      rspUserMode <= 1'b0;
      rspVector <= 32'h00000000;
      lastCause_q <= `EXC_NONE;
      lastAddr_q <= 32'h00000000;
   end else begin
      rspValid <= reqValid;
      rspUserMode <= userMode_q;
      rspVector <= vecLow ? FAST_MISS_VECTOR : EXC_VECTOR;
      if (reqValid) begin
         rspPaddr <= physD;
         rspCacheable <= (causeD == `EXC_NONE) ? cacheD : 1'b0;
         rspCause <= causeD;
         if (causeD == `EXC_FAST_MISS)
            rspVector <= FAST_MISS_VECTOR;
         else
            rspVector <= EXC_VECTOR;
         if (causeD != `EXC_NONE) begin
            lastCause_q <= causeD;
            lastAddr_q <= reqVaddr;
         end
      end
   end
end

// ----------------------------------------------------------------
// apb slave: control, status and table load
// ----------------------------------------------------------------
// register map, one aligned word each:
//   0x00 control    [0] user mode, [1] handler flag, [15:8] process id
//   0x04 status     [0] user mode, [1] user level available, [2] data cache
//   0x08 table tag  [31:12] page, [8] global, [7:0] process id
//   0x0c table data [31:12] frame, [8] cacheable, [7:4] perm, [3:0] index
//   0x10 commit     any write copies the staged tag and data into the table
//   0x14 last cause cause code of the most recent fault
//   0x18 last addr  virtual address of the most recent fault
// read data is loaded in the setup cycle and stands in the access cycle;
// pready rises in the access cycle, so every transfer takes two cycles;
// writes take effect at the edge that ends the access cycle;
// unmapped offsets answer with pslverr together with pready
// user mode cannot be set when neither translation nor region protection
// is configured; the bit then always reads back as zero
wire wrEn = psel && penable && pwrite;

always @(posedge ref_clk or posedge rst) begin
   if (rst) begin
      userMode_q <= 1'b0;
      handlerFlag_q <= 1'b0;
      processIdentifier_q <= {`PID_W{1'b0}};
      stageVpn_q <= 20'h00000;
      stagePid_q <= {`PID_W{1'b0}};
      stageGlobal_q <= 1'b0;
      stagePfn_q <= 20'h00000;
      stagePerm_q <= 4'h0;
      stageIdx_q <= {`TLB_IDX_W{1'b0}};
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h00000000;
   end else begin
      pready <= psel && !penable;
      pslverr <= 1'b0;
      if (psel && !penable) begin
         case (paddr[11:0])
            `REG_CTRL: prdata <= {16'h0000, processIdentifier_q, 6'h00, handlerFlag_q, userMode_q};
            `REG_STATUS: prdata <= {29'h0, hasDcache, USER_OK ? 1'b1 : 1'b0, userMode_q};
            `REG_TLB_TAG: prdata <= {stageVpn_q, 3'h0, stageGlobal_q, stagePid_q};
            `REG_TLB_DATA: prdata <= {stagePfn_q, 3'h0, stageCData_q, stagePerm_q, stageIdx_q};
            `REG_TLB_WRITE: prdata <= 32'h00000000;
            `REG_LAST_CAUSE: prdata <= {29'h0, lastCause_q};
            `REG_LAST_ADDR: prdata <= lastAddr_q;
            default: begin
               prdata <= 32'h00000000;
               pslverr <= 1'b1;
            end
         endcase
      end
      if (wrEn && pready) begin
         case (paddr[11:0])
            `REG_CTRL: begin
               userMode_q <= pwdata[0] && USER_OK;
               handlerFlag_q <= pwdata[1];
               processIdentifier_q <= pwdata[`PID_W+7:8];
            end
            `REG_TLB_TAG: begin
               stageVpn_q <= pwdata[31:12];
               stageGlobal_q <= pwdata[8];
               stagePid_q <= pwdata[`PID_W-1:0];
            end
            `REG_TLB_DATA: begin
               stagePfn_q <= pwdata[31:12];
               stagePerm_q <= pwdata[7:4];
               stageIdx_q <= pwdata[`TLB_IDX_W-1:0];
            end
            default: ;
         endcase
      end
   end
end

// cacheable staging bit kept apart from the permission nibble
always @(posedge ref_clk or posedge rst) begin
   if (rst)
      stageCData_q <= 1'b0;
   else if (wrEn && pready && paddr[11:0] == `REG_TLB_DATA)
      stageCData_q <= pwdata[8];
end

// table entries change only at reset and on a software commit write
// lookups only read the arrays; there is no refill path from hardware,
// a miss is reported and software loads the entry through the registers
integer j;
always @(posedge ref_clk or posedge rst) begin
   if (rst) begin
      for (j = 0; j < `TLB_ENTRIES; j = j + 1) begin
         tagVpn[j] <= 20'hfffff - j[19:0]; // distinct peripheral-range pages
         tagPid[j] <= {`PID_W{1'b0}};
         tagGlobal[j] <= 1'b1;
         dataPfn[j] <= 20'h00000;
         dataPerm[j] <= 4'h0;
         dataC[j] <= 1'b0;
      end
   end else if (wrEn && pready && paddr[11:0] == `REG_TLB_WRITE) begin
      tagVpn[stageIdx_q] <= stageVpn_q;
      tagPid[stageIdx_q] <= stagePid_q;
      tagGlobal[stageIdx_q] <= stageGlobal_q;
      dataPfn[stageIdx_q] <= stagePfn_q;
      dataPerm[stageIdx_q] <= stagePerm_q;
      dataC[stageIdx_q] <= stageCData_q;
   end
end

endmodule

// [common/mmu_partition_consts.vh]
`ifndef MMU_PARTITION_CONSTS_VH
`define MMU_PARTITION_CONSTS_VH
// partition codes from virtual address bits 31:29
`define PART_USER 2'h0
`define PART_KXLAT 2'h1
`define PART_KERNEL 2'h2
`define PART_IO 2'h3
// address field layout
`define PAGE_MSB 31
`define PAGE_LSB 12
`define OFFSET_MSB 11
`define BYPASS_MSB 28
// exception cause codes
`define EXC_NONE 3'h0
`define EXC_FAST_MISS 3'h1
`define EXC_DOUBLE_MISS 3'h2
`define EXC_PERM 3'h3
`define EXC_SUPER_ONLY 3'h4
`define EXC_PRIV_INSTR 3'h5
// access kinds
`define ACC_FETCH 2'h0
`define ACC_LOAD 2'h1
`define ACC_STORE 2'h2
`define ACC_FLUSH 2'h3
// table size and register offsets
`define TLB_ENTRIES 16
`define TLB_IDX_W 4
`define PID_W 8
`define REG_CTRL 12'h000
`define REG_STATUS 12'h004
`define REG_TLB_TAG 12'h008
`define REG_TLB_DATA 12'h00c
`define REG_TLB_WRITE 12'h010
`define REG_LAST_CAUSE 12'h014
`define REG_LAST_ADDR 12'h018
`define CTRL_RESET 32'h00000000
`endif

// [testbench/mmu_partition_checker_sva.sv]
`timescale 1ns/1ps
`include "mmu_partition_consts.vh"
// ----------------------------------------
// translation port checker
// ----------------------------------------
module mmu_partition_checker (
   input logic ref_clk,
   input logic rst,
   input logic reqValid,
   input logic [31:0] reqVaddr,
   input logic [1:0] reqKind,
   input logic reqIoType,
   input logic reqPrivInstr,
   input logic rspValid,
   input logic [31:0] rspPaddr,
   input logic rspCacheable,
   input logic [2:0] rspCause,
   input logic rspUserMode,
   input logic psel,
   input logic penable,
   input logic pready
);
   default clocking @(posedge ref_clk); endclocking
   default disable iff (rst);
   // request classes by partition, and the register setup cycle
   sequence s_io; reqValid && reqVaddr[31:29] == 3'h7; endsequence
   sequence s_ker; reqValid && reqVaddr[31:29] == 3'h6 && !reqIoType && reqKind != `ACC_FETCH; endsequence
   sequence s_xl; reqValid && reqVaddr[31:30] != 2'h3; endsequence
   sequence s_setup; psel && !penable; endsequence
   property p_rsp; 1 |=> rspValid == $past(reqValid); endproperty
   a_rsp: assert property (p_rsp) else $error("response not one cycle after request");
   property p_io; s_io |=> rspCause != `EXC_NONE || (rspPaddr == {3'h0, $past(reqVaddr[28:0])} && !rspCacheable);
   endproperty
   a_io: assert property (p_io) else $error("peripheral bypass wrong");
   property p_ker; s_ker |=> rspCause != `EXC_NONE || (rspPaddr == {3'h0, $past(reqVaddr[28:0])} && rspCacheable);
   endproperty
   a_ker: assert property (p_ker) else $error("kernel bypass wrong");
   property p_off; s_xl |=> rspCause != `EXC_NONE || rspPaddr[11:0] == $past(reqVaddr[11:0]); endproperty
   a_off: assert property (p_off) else $error("page offset altered");
   property p_iot; reqValid && reqIoType && reqKind[1] != reqKind[0] |=> !rspCacheable; endproperty
   a_iot: assert property (p_iot) else $error("peripheral access cached");
   property p_sup; reqValid && rspUserMode && reqVaddr[31] |=> rspCause inside {`EXC_SUPER_ONLY, `EXC_PRIV_INSTR};
   endproperty
   a_sup: assert property (p_sup) else $error("user reached supervisor partition");
   property p_prv; reqValid && reqPrivInstr && rspUserMode |=> rspCause == `EXC_PRIV_INSTR; endproperty
   a_prv: assert property (p_prv) else $error("privileged instruction allowed");
   property p_apb; s_setup |=> pready; endproperty
   a_apb: assert property (p_apb) else $error("register access not answered");
endmodule
bind mmu_partition_translation mmu_partition_checker u_chk (.ref_clk(ref_clk), .rst(rst), .reqValid(reqValid),
   .reqVaddr(reqVaddr), .reqKind(reqKind), .reqIoType(reqIoType), .reqPrivInstr(reqPrivInstr), .rspValid(rspValid),
   .rspPaddr(rspPaddr), .rspCacheable(rspCacheable), .rspCause(rspCause), .rspUserMode(rspUserMode), .psel(psel),
   .penable(penable), .pready(pready));

// [testbench/cpu_port_model.sv]
`timescale 1ns/1ps
// ----------------------------------------
// processor request side
// ----------------------------------------
module cpu_port_model (
   input logic ref_clk,
   output logic reqValid,
   output logic [31:0] reqVaddr,
   output logic [1:0] reqKind,
   output logic reqIoType,
   output logic reqPrivInstr
);
   // idle values at time zero
   initial begin
      reqValid = 1'b0;
      reqVaddr = 32'h0;
      reqKind = 2'h0;
      reqIoType = 1'b0;
      reqPrivInstr = 1'b0;
   end
   // one request; the address is scrambled after so no stale value lingers
   task issue(input logic [31:0] va, input logic [1:0] k, input logic io, input logic pi);
      @(posedge ref_clk);
      reqValid <= 1'b1;
      reqVaddr <= va;
      reqKind <= k;
      reqIoType <= io;
      reqPrivInstr <= pi;
      @(posedge ref_clk);
      reqValid <= 1'b0;
      reqVaddr <= ~va;
      #1;
   endtask
endmodule

// [testbench/mmu_partition_translation_test.sv]
`timescale 1ns/1ps
`include "mmu_partition_consts.vh"
module mmu_partition_translation_test;
   logic ref_clk, rst, reqValid, reqIoType, reqPrivInstr, rspValid, rspCacheable, rspUserMode;
   logic psel, penable, pwrite, pready, pslverr, er;
   logic [31:0] reqVaddr, rspPaddr, rspVector, paddr, pwdata, prdata, rd, va;
   logic [1:0] reqKind;
   logic [2:0] rspCause;
   integer n_fail, tests_run, i;
   // ----------------------------------------
   // clock, instances, helpers
   // ----------------------------------------
   initial begin
      ref_clk = 1'b0;
      forever #12.5 ref_clk = ~ref_clk;
   end
   mmu_partition_translation dut (.ref_clk(ref_clk), .rst(rst), .reqValid(reqValid), .reqVaddr(reqVaddr),
      .reqKind(reqKind), .reqIoType(reqIoType), .reqPrivInstr(reqPrivInstr), .rspValid(rspValid), .rspPaddr(rspPaddr),
      .rspCacheable(rspCacheable), .rspCause(rspCause), .rspUserMode(rspUserMode), .rspVector(rspVector),
      .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr));
   cpu_port_model cpu (.ref_clk(ref_clk), .reqValid(reqValid), .reqVaddr(reqVaddr), .reqKind(reqKind),
      .reqIoType(reqIoType), .reqPrivInstr(reqPrivInstr));
   function logic [31:0] byp(input logic [31:0] a);
      return {3'h0, a[28:0]};
   endfunction
   function logic cch(input logic [31:0] a, input logic io);
      return a[31:29] == 3'h6 && !io;
   endfunction
   task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      tests_run++;
      if (g !== e) begin
         n_fail++;
         $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
      end
   endtask
   // register access: setup, access until pready, release
   task apb(input logic w, input logic [31:0] a, input logic [31:0] d);
      integer k;
      @(posedge ref_clk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge ref_clk);
      penable <= 1'b1;
      k = 0;
      @(posedge ref_clk);
      while (pready !== 1'b1 && k < 20) begin
         @(posedge ref_clk);
         k++;
      end
      if (k == 20) chk("pready", 32'h1, 32'h0);
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task ctl(input logic um, input logic eh, input logic [7:0] process_identifier);
      apb(1'b1, 32'h0, {16'h0, process_identifier, 6'h0, eh, um});
   endtask
   task ld(input logic [3:0] ix, input logic [19:0] pg, input logic g, input logic [7:0] process_identifier, input logic [19:0] fr,
      input logic c, input logic [3:0] pm);
      apb(1'b1, 32'h8, {pg, 3'h0, g, process_identifier});
      apb(1'b1, 32'hc, {fr, 3'h0, c, pm, ix});
      apb(1'b1, 32'h10, 32'h0);
   endtask
   task acc(input logic [31:0] a, input logic [1:0] k, input logic io, input logic pi, input logic [2:0] ec,
      input logic [31:0] ep, input logic c);
      cpu.issue(a, k, io, pi);
      chk("rspValid", 32'h1, {31'h0, rspValid});
      chk("rspCause", {29'h0, ec}, {29'h0, rspCause});
      chk("rspVector", (ec == `EXC_FAST_MISS) ? 32'hc0000060 : 32'hc0000020, rspVector);
      if (ec == `EXC_NONE) chk("rspPaddr", ep, rspPaddr);
      if (ec == `EXC_NONE && k != `ACC_FETCH) chk("rspCacheable", {31'h0, c}, {31'h0, rspCacheable});
   endtask
   task tally_and_finish;
      $display("checks %0d failures %0d", tests_run, n_fail);
      if (n_fail == 0 && tests_run > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask
   // watchdog
   initial begin
      #500000;
      n_fail++;
      tally_and_finish;
   end
   // main sequence
   initial begin
      n_fail = 0;
      tests_run = 0;
      rst = 1'b1;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 32'h0;
      pwdata = 32'h0;
      void'($urandom(32'hc5cc));
      repeat (6) @(posedge ref_clk);
      rst <= 1'b0;
      for (i = 0; i < 24; i++) begin
         va = $urandom;
         va[31:30] = 2'h3;
         acc(va, {va[6], ~va[6]}, va[5], 1'b0, `EXC_NONE, byp(va), cch(va, va[5]));
      end
      chk("rspUserMode", 32'h0, {31'h0, rspUserMode});
      apb(1'b0, 32'h4, 32'h0);
      chk("status", 32'h6, {29'h0, rd[2:0]});
      apb(1'b0, 32'h40, 32'h0);
      chk("pslverr", 32'h1, {31'h0, er});
      ld(4'h0, 20'h00123, 1'b0, 8'h5, 20'h3f001, 1'b1, 4'hd);
      ld(4'h1, 20'h00124, 1'b0, 8'h5, 20'h3f002, 1'b1, 4'h6);
      ld(4'h2, 20'h80456, 1'b1, 8'h9, 20'h00abc, 1'b0, 4'h6);
      ctl(1'b0, 1'b0, 8'h5);
      for (i = 0; i < 8; i++) begin
         va = $urandom;
         va[31:12] = 20'h00123;
         acc(va, `ACC_LOAD, va[0], 1'b0, `EXC_NONE, {20'h3f001, va[11:0]}, !va[0]);
         acc(va, `ACC_FETCH, 1'b0, 1'b0, `EXC_NONE, {20'h3f001, va[11:0]}, 1'b0);
         acc(va, `ACC_STORE, 1'b0, 1'b0, `EXC_PERM, 32'h0, 1'b0);
         acc({20'h80456, va[11:0]}, `ACC_STORE, 1'b0, 1'b0, `EXC_NONE, {20'h00abc, va[11:0]}, 1'b0);
      end
      ctl(1'b0, 1'b0, 8'h6);
      acc(32'h00123010, `ACC_LOAD, 1'b0, 1'b0, `EXC_FAST_MISS, 32'h0, 1'b0);
      acc(32'h80456010, `ACC_LOAD, 1'b0, 1'b0, `EXC_NONE, 32'h00abc010, 1'b0);
      ctl(1'b0, 1'b1, 8'h6);
      acc(32'h00123010, `ACC_LOAD, 1'b0, 1'b0, `EXC_DOUBLE_MISS, 32'h0, 1'b0);
      ctl(1'b1, 1'b0, 8'h5);
      apb(1'b0, 32'h4, 32'h0);
      chk("status", 32'h7, {29'h0, rd[2:0]});
      acc(32'h00123ffc, `ACC_LOAD, 1'b0, 1'b0, `EXC_NONE, 32'h3f001ffc, 1'b1);
      chk("rspUserMode", 32'h1, {31'h0, rspUserMode});
      cpu.issue(32'h00124008, `ACC_LOAD, 1'b0, 1'b0);
      chk("userFault", 32'h1, {31'h0, rspCause != `EXC_NONE});
      acc(32'hc0001000, `ACC_LOAD, 1'b0, 1'b0, `EXC_SUPER_ONLY, 32'h0, 1'b0);
      acc(32'he0000000, `ACC_LOAD, 1'b1, 1'b0, `EXC_SUPER_ONLY, 32'h0, 1'b0);
      acc(32'h80456000, `ACC_LOAD, 1'b0, 1'b0, `EXC_SUPER_ONLY, 32'h0, 1'b0);
      acc(32'h00123000, `ACC_FETCH, 1'b0, 1'b1, `EXC_PRIV_INSTR, 32'h0, 1'b0);
      apb(1'b0, 32'h14, 32'h0);
      chk("lastCause", {29'h0, `EXC_PRIV_INSTR}, rd);
      apb(1'b0, 32'h18, 32'h0);
      chk("lastAddr", 32'h00123000, rd);
      tally_and_finish;
   end
endmodule
